// file: src/lsrs_switch.sv
// Our own choices: the address map and the APB slave port.
module lsrs_switch (
	// Clock, reset, enable
	input  wire logic        core_clk_in,
	input  wire logic        srst_in,
	input  wire logic        ce_in,
	// APB slave
	input  wire logic [7:0]  paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Fast lanes, A0..D3
	input  wire logic [15:0] fast_lane_in,
	output logic      [3:0]  fast_lane_out,
	output logic      [3:0]  fast_lane_oe_out,
	output logic             fast_standby_out,
	// Auxiliary signals, A0..D3, and the common port
	input  wire logic [15:0] aux_src_in,
	output logic      [3:0]  aux_com_out,
	output logic      [3:0]  aux_com_oe_out
);

	// Register file
	lsrs_pkg::lsrs_cfg_s     fast_cfg_reg;
	lsrs_pkg::lsrs_cfg_s     fast_cfg_next;
	lsrs_pkg::lsrs_cfg_s     aux_cfg_reg;
	lsrs_pkg::lsrs_cfg_s     aux_cfg_next;
	logic                    fast_rej_reg;
	logic                    fast_rej_next;
	logic                    aux_rej_reg;
	logic                    aux_rej_next;
	lsrs_pkg::lsrs_apb_ans_s ans_reg;
	lsrs_pkg::lsrs_apb_ans_s ans_next;

	// Pin synchronisers and filtered lanes
	logic [31:0]             pin_s1_reg;
	logic [31:0]             pin_s2_reg;
	logic [31:0]             pin_s3_reg;
	logic [31:0]             pin_filt_reg;
	logic [31:0]             pin_filt_next;
	logic [15:0]             fast_filt;
	logic [15:0]             aux_filt;

	// Routed outputs
	logic [3:0]              fast_lane_reg;
	logic [3:0]              fast_lane_next;
	logic [3:0]              aux_com_reg;
	logic [3:0]              aux_com_next;
	logic                    fast_on_reg;
	logic                    aux_on_reg;

	// Decode and datapath wires
	wire logic               hit_fast;
	wire logic               hit_aux;
	wire logic               hit_status;
	wire logic               hit_any;
	wire logic               access;
	wire logic               wr_fast;
	wire logic               wr_aux;
	wire logic [1:0]         wr_mode;
	wire logic               wr_illegal;
	wire logic [7:0]         status_byte;
	wire logic [7:0]         rd_byte;
	lsrs_pkg::lsrs_idx_t     fast_idx;
	lsrs_pkg::lsrs_idx_t     aux_idx;

	// Address decode shared by read and write paths
	function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
		reg_hit = (addr == {idx, lsrs_pkg::WORD_ALIGN});
	endfunction

	// Pick four lanes by index
	function automatic logic [3:0] pick_lanes(input logic [15:0] lanes, input lsrs_pkg::lsrs_idx_t idx);
		logic [3:0] res;
		res = 4'h0;
		for (int k = 0; k < lsrs_pkg::OUT_LANES; k++) begin
			res[k] = lanes[idx[k]];
		end
		return res;
	endfunction

	// Turn a written byte into a configuration, keeping the old mode on 11
	function automatic lsrs_pkg::lsrs_cfg_s load_cfg(input lsrs_pkg::lsrs_cfg_s old, input logic [7:0] wb);
		lsrs_pkg::lsrs_cfg_s res;
		res.enable = wb[lsrs_pkg::EN_BIT];
		res.sel    = wb[lsrs_pkg::SEL_LSB +: 4];
		res.mode   = (wb[lsrs_pkg::MODE_LSB +: 2] == lsrs_pkg::MODE_ILLEGAL) ? old.mode
		             : wb[lsrs_pkg::MODE_LSB +: 2];
		return res;
	endfunction

	// Register the configuration as a byte for read-back
	function automatic logic [7:0] cfg_byte(input lsrs_pkg::lsrs_cfg_s c);
		logic [7:0] res;
		res = 8'h00;
		res[lsrs_pkg::EN_BIT]        = c.enable;
		res[lsrs_pkg::MODE_LSB +: 2] = c.mode;
		res[lsrs_pkg::SEL_LSB +: 4]  = c.sel;
		return res;
	endfunction

	// APB decode; a write lands only on the completing access edge
	assign hit_fast   = reg_hit(paddr_in, lsrs_pkg::IDX_FAST);
	assign hit_aux    = reg_hit(paddr_in, lsrs_pkg::IDX_AUX);
	assign hit_status = reg_hit(paddr_in, lsrs_pkg::IDX_STATUS);
	assign hit_any    = hit_fast | hit_aux | hit_status;
	assign access     = psel_in & penable_in & pready_out;
	assign wr_fast    = access & pwrite_in & hit_fast;
	assign wr_aux     = access & pwrite_in & hit_aux;
	assign wr_mode    = pwdata_in[lsrs_pkg::MODE_LSB +: 2];
	assign wr_illegal = (wr_mode == lsrs_pkg::MODE_ILLEGAL);

	// Ready waits for one enabled edge in setup so read data is already registered
	assign pready_out  = ans_reg.ok & penable_in & ce_in;
	assign pslverr_out = pready_out & ~hit_any;
	assign prdata_out  = ans_reg.rdata;

	// Read mux; unmapped reads return zero
	assign status_byte = {4'h0, aux_rej_reg, fast_rej_reg, aux_on_reg, ~fast_on_reg};
	assign rd_byte     = hit_fast   ? cfg_byte(fast_cfg_reg) :
	                     hit_aux    ? cfg_byte(aux_cfg_reg)  :
	                     hit_status ? status_byte            : 8'h00;

	// Configuration updates; enable and select take the written value even on a rejected mode
	assign fast_cfg_next = wr_fast ? load_cfg(fast_cfg_reg, pwdata_in[7:0]) : fast_cfg_reg;
	assign aux_cfg_next  = wr_aux  ? load_cfg(aux_cfg_reg, pwdata_in[7:0])  : aux_cfg_reg;
	assign fast_rej_next = wr_fast ? wr_illegal : fast_rej_reg;
	assign aux_rej_next  = wr_aux  ? wr_illegal : aux_rej_reg;
	assign ans_next.ok    = psel_in & ~access;
	assign ans_next.rdata = {24'h000000, rd_byte};

	// Register file; the whole block holds still while ce_in is low
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			fast_cfg_reg <= lsrs_pkg::lsrs_cfg_s'(lsrs_pkg::FAST_RESET[6:0]);
			aux_cfg_reg  <= lsrs_pkg::lsrs_cfg_s'(lsrs_pkg::AUX_RESET[6:0]);
			fast_rej_reg <= 1'b0;
			aux_rej_reg  <= 1'b0;
			ans_reg      <= '0;
		end else if (ce_in) begin
			fast_cfg_reg <= fast_cfg_next;
			aux_cfg_reg  <= aux_cfg_next;
			fast_rej_reg <= fast_rej_next;
			aux_rej_reg  <= aux_rej_next;
			ans_reg      <= ans_next;
		end
	end

	// A pin change is accepted only once two later stages agree, which rejects one-cycle glitches
	assign pin_filt_next = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg : pin_filt_reg;
	assign fast_filt     = pin_filt_reg[15:0];
	assign aux_filt      = pin_filt_reg[31:16];

	// Three-stage pin synchroniser
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			pin_s1_reg   <= 32'h00000000;
			pin_s2_reg   <= 32'h00000000;
			pin_s3_reg   <= 32'h00000000;
			pin_filt_reg <= 32'h00000000;
		end else if (ce_in) begin
			pin_s1_reg   <= {aux_src_in, fast_lane_in};
			pin_s2_reg   <= pin_s1_reg;
			pin_s3_reg   <= pin_s2_reg;
			pin_filt_reg <= pin_filt_next;
		end
	end

	// Lane index maps for the two switches
	lsrs_route_map u_fast_map (
		.cfg_in       (fast_cfg_reg),
		.aux_style_in (1'b0),
		.idx_out      (fast_idx)
	);

	lsrs_route_map u_aux_map (
		.cfg_in       (aux_cfg_reg),
		.aux_style_in (1'b1),
		.idx_out      (aux_idx)
	);

	// Disabled paths drive zero so a stale lane never leaks out
	assign fast_lane_next = fast_cfg_reg.enable ? pick_lanes(fast_filt, fast_idx) : 4'h0;
	assign aux_com_next   = aux_cfg_reg.enable  ? pick_lanes(aux_filt, aux_idx)   : 4'h0;

	// Routed outputs and their enables
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			fast_lane_reg <= 4'h0;
			aux_com_reg   <= 4'h0;
			fast_on_reg   <= 1'b0;
			aux_on_reg    <= 1'b0;
		end else if (ce_in) begin
			fast_lane_reg <= fast_lane_next;
			aux_com_reg   <= aux_com_next;
			fast_on_reg   <= fast_cfg_reg.enable;
			aux_on_reg    <= aux_cfg_reg.enable;
		end
	end

	assign fast_lane_out    = fast_lane_reg;
	assign fast_lane_oe_out = {4{fast_on_reg}};
	assign fast_standby_out = ~fast_on_reg;
	assign aux_com_out      = aux_com_reg;
	assign aux_com_oe_out   = {4{aux_on_reg}};

	// Checks
	default clocking chk_cb @(posedge core_clk_in);
	endclocking
	default disable iff (srst_in);

	chk_fast_reject: assert property (
		ce_in && wr_fast && wr_illegal |=> fast_cfg_reg.mode == $past(fast_cfg_reg.mode))
		else $error("fast mode changed on an illegal write");

	chk_aux_reject: assert property (
		ce_in && wr_aux && wr_illegal |=> aux_cfg_reg.mode == $past(aux_cfg_reg.mode) && aux_rej_reg)
		else $error("aux mode changed on an illegal write");

	chk_mode_legal: assert property (
		fast_cfg_reg.mode != lsrs_pkg::MODE_ILLEGAL && aux_cfg_reg.mode != lsrs_pkg::MODE_ILLEGAL)
		else $error("illegal mode code held");

	chk_fast_quad: assert property (
		ce_in && fast_cfg_reg.enable && fast_cfg_reg.mode == lsrs_pkg::MODE_QUAD
		|=> fast_lane_out == $past(fast_filt[{fast_cfg_reg.sel[1:0], 2'h0} +: 4]))
		else $error("fast quad routing wrong");

	chk_fast_dual: assert property (
		ce_in && fast_cfg_reg.enable && fast_cfg_reg.mode == lsrs_pkg::MODE_DUAL
		|=> fast_lane_out == {{2{$past(fast_filt[{fast_cfg_reg.sel[2:0], 1'b1}])}},
		                      {2{$past(fast_filt[{fast_cfg_reg.sel[2:0], 1'b0}])}}})
		else $error("fast dual routing wrong");

	chk_fast_single: assert property (
		ce_in && fast_cfg_reg.enable && fast_cfg_reg.mode == lsrs_pkg::MODE_SINGLE
		|=> fast_lane_out == {4{$past(fast_filt[fast_cfg_reg.sel])}})
		else $error("fast single routing wrong");

	chk_aux_quad: assert property (
		ce_in && aux_cfg_reg.enable && aux_cfg_reg.mode == lsrs_pkg::MODE_QUAD
		|=> aux_com_out == $past(aux_filt[{aux_cfg_reg.sel[1:0], 2'h0} +: 4]))
		else $error("aux quad routing wrong");

	chk_aux_dual: assert property (
		ce_in && aux_cfg_reg.enable && aux_cfg_reg.mode == lsrs_pkg::MODE_DUAL
		|=> aux_com_out == {{2{$past(aux_filt[{1'b1, aux_cfg_reg.sel[2:0]}])}},
		                    {2{$past(aux_filt[{1'b0, aux_cfg_reg.sel[2:0]}])}}})
		else $error("aux dual routing wrong");

	chk_aux_single: assert property (
		ce_in && aux_cfg_reg.enable && aux_cfg_reg.mode == lsrs_pkg::MODE_SINGLE
		|=> aux_com_out == {4{$past(aux_filt[aux_cfg_reg.sel])}})
		else $error("aux single routing wrong");

	chk_aux_off: assert property (
		ce_in && !aux_cfg_reg.enable |=> aux_com_oe_out == 4'h0 && aux_com_out == 4'h0)
		else $error("aux port connected while disabled");

	chk_fast_standby: assert property (
		ce_in && !fast_cfg_reg.enable ##1 ce_in && !fast_cfg_reg.enable
		|=> fast_standby_out && fast_lane_oe_out == 4'h0 && fast_lane_out == 4'h0)
		else $error("fast lanes active in standby");

	chk_fast_write: assert property (
		ce_in && wr_fast && !wr_illegal
		|=> cfg_byte(fast_cfg_reg) == {1'b0, $past(pwdata_in[lsrs_pkg::EN_BIT:0])})
		else $error("fast control write did not land");

	chk_aux_write: assert property (
		ce_in && wr_aux && !wr_illegal
		|=> cfg_byte(aux_cfg_reg) == {1'b0, $past(pwdata_in[lsrs_pkg::EN_BIT:0])})
		else $error("aux control write did not land");

	// Zero wait states whenever the setup edge and the access edge are both enabled ones
	chk_ready_zero_wait: assert property (
		ce_in && psel_in && !penable_in ##1 ce_in && psel_in && penable_in |-> pready_out)
		else $error("ready missing in the access cycle");

	// An error answer must leave both control words alone
	chk_unmapped_quiet: assert property (
		pready_out && !hit_any |=> $stable(fast_cfg_reg) && $stable(aux_cfg_reg))
		else $error("unmapped access changed a control word");

	// Reset is kept out of the antecedent because the on-flop clears on that edge
	chk_fast_on: assert property (
		ce_in && !srst_in |=> fast_standby_out == !$past(fast_cfg_reg.enable))
		else $error("standby does not follow the fast enable");

	cov_dual_fast: cover property (fast_cfg_reg.enable && fast_cfg_reg.mode == lsrs_pkg::MODE_DUAL);
	cov_single_aux: cover property (aux_cfg_reg.enable && aux_cfg_reg.mode == lsrs_pkg::MODE_SINGLE);
	cov_reject: cover property (ce_in && wr_fast && wr_illegal);
	cov_unmapped: cover property (pslverr_out);
	cov_ce_frozen: cover property (!ce_in ##1 !ce_in);

endmodule // lsrs_switch

// file: src/lsrs_pkg.sv
package lsrs_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned REG_W     = 8;

	// Register indices; the byte address is four times the index
	localparam logic [5:0]  IDX_FAST   = 6'h00;
	localparam logic [5:0]  IDX_AUX    = 6'h01;
	localparam logic [5:0]  IDX_STATUS = 6'h02;
	localparam logic [1:0]  WORD_ALIGN = 2'h0;

	// Field layout of both routing control registers
	localparam int unsigned EN_BIT     = 6;
	localparam int unsigned MODE_LSB   = 4;
	localparam int unsigned SEL_LSB    = 0;

	// Field layout of the status register
	localparam int unsigned ST_STANDBY = 0;
	localparam int unsigned ST_AUX_ON  = 1;
	localparam int unsigned ST_FAST_REJ = 2;
	localparam int unsigned ST_AUX_REJ = 3;

	// Reset values
	localparam logic [7:0]  FAST_RESET = 8'h40;
	localparam logic [7:0]  AUX_RESET  = 8'h40;

	// Bundling mode codes
	localparam logic [1:0]  MODE_QUAD    = 2'h0;
	localparam logic [1:0]  MODE_DUAL    = 2'h1;
	localparam logic [1:0]  MODE_SINGLE  = 2'h2;
	localparam logic [1:0]  MODE_ILLEGAL = 2'h3;

	// Lane counts
	localparam int unsigned NUM_LANES = 16;
	localparam int unsigned OUT_LANES = 4;

	// One routing configuration as held in a control register
	typedef struct packed {
		logic       enable;
		logic [1:0] mode;
		logic [3:0] sel;
	} lsrs_cfg_s;

	// Source lane index for each of the four output bits
	typedef logic [3:0][3:0] lsrs_idx_t;

	// Registered APB answer
	typedef struct packed {
		logic [31:0] rdata;
		logic        ok;
	} lsrs_apb_ans_s;

endpackage

// file: src/lsrs_route_map.sv
// Turns a mode and a source select into one source lane index per output bit
module lsrs_route_map (
	// Configuration
	input  wire lsrs_pkg::lsrs_cfg_s cfg_in,
	input  wire logic                aux_style_in,
	// Lane indices, lanes ordered A0..A3, B0..B3, C0..C3, D0..D3
	output lsrs_pkg::lsrs_idx_t      idx_out
);

	// Candidate maps for each mode
	lsrs_pkg::lsrs_idx_t quad_idx;
	lsrs_pkg::lsrs_idx_t dual_fast_idx;
	lsrs_pkg::lsrs_idx_t dual_aux_idx;
	lsrs_pkg::lsrs_idx_t single_idx;
	lsrs_pkg::lsrs_idx_t dual_idx;

	// Quad: whole source by the low two select bits, upper bits ignored
	assign quad_idx[0] = {cfg_in.sel[1:0], 2'h0};
	assign quad_idx[1] = {cfg_in.sel[1:0], 2'h1};
	assign quad_idx[2] = {cfg_in.sel[1:0], 2'h2};
	assign quad_idx[3] = {cfg_in.sel[1:0], 2'h3};

	// Fast dual: pair n is lanes 2n and 2n+1, low lane on bits 1:0
	assign dual_fast_idx[0] = {cfg_in.sel[2:0], 1'b0};
	assign dual_fast_idx[1] = {cfg_in.sel[2:0], 1'b0};
	assign dual_fast_idx[2] = {cfg_in.sel[2:0], 1'b1};
	assign dual_fast_idx[3] = {cfg_in.sel[2:0], 1'b1};

	// Aux dual: A or B on bits 1:0, C or D of the same channel on bits 3:2
	assign dual_aux_idx[0] = {1'b0, cfg_in.sel[2:0]};
	assign dual_aux_idx[1] = {1'b0, cfg_in.sel[2:0]};
	assign dual_aux_idx[2] = {1'b1, cfg_in.sel[2:0]};
	assign dual_aux_idx[3] = {1'b1, cfg_in.sel[2:0]};

	// Single: one lane of sixteen, copied onto every output bit
	assign single_idx = {4{cfg_in.sel}};

	assign dual_idx = aux_style_in ? dual_aux_idx : dual_fast_idx;

	// Illegal code is never held, so it falls back to quad
	assign idx_out = (cfg_in.mode == lsrs_pkg::MODE_DUAL)   ? dual_idx   :
	                 (cfg_in.mode == lsrs_pkg::MODE_SINGLE) ? single_idx :
	                 quad_idx;

endmodule // lsrs_route_map

// file: bench/lsrs_cable_model.sv
// Four cable sources feeding the switch; pins move one edge after the bench asks
module lsrs_cable_model (
	// Clock
	input  wire logic        core_clk_in,
	// Patterns wanted on the pins, A0..D3
	input  wire logic [15:0] fast_pat_in,
	input  wire logic [15:0] aux_pat_in,
	// Pins towards the switch
	output logic      [15:0] fast_lane_out,
	output logic      [15:0] aux_src_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Registered so the pins never change in the same step as the sampling edge
	always @(posedge core_clk_in) begin
		fast_lane_out <= fast_pat_in;
		aux_src_out   <= aux_pat_in;
	end
endmodule // lsrs_cable_model

// file: bench/tb_link_switch_route_select.sv
module tb_link_switch_route_select;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {int kind; logic [32:0] exp; string name;} lsrs_note_s;
	logic        core_clk_in, srst_in, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, standby, ce;
	logic [15:0] fpat, apat, fpin, apin;
	logic [3:0]  fout, foe, aout, aoe;
	logic [7:0]  fcfg, acfg;
	int          fail_count, total_checks, cycles;
	lsrs_note_s  q[$];
	event        look;

	lsrs_cable_model lsrs_cable_model_i (.core_clk_in(core_clk_in), .fast_pat_in(fpat), .aux_pat_in(apat),
		.fast_lane_out(fpin), .aux_src_out(apin));
	lsrs_switch lsrs_switch_i (.core_clk_in(core_clk_in), .srst_in(srst_in), .ce_in(ce), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .fast_lane_in(fpin), .fast_lane_out(fout),
		.fast_lane_oe_out(foe), .fast_standby_out(standby), .aux_src_in(apin), .aux_com_out(aout),
		.aux_com_oe_out(aoe));

	// Clock and a hang guard sized well above the planned run
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Expected routing, worked out independently of the design
	function automatic logic [3:0] route(logic [7:0] c, logic [15:0] p, bit aux);
		logic [3:0] s;
		s = c[3:0];
		if (!c[6])
			return 4'h0;
		case (c[5:4])
			2'h0: return p[4*s[1:0] +: 4];
			2'h1: if (aux) return {{2{p[{1'b1, s[2:0]}]}}, {2{p[{1'b0, s[2:0]}]}}};
				else return {{2{p[{s[2:0], 1'b1}]}}, {2{p[{s[2:0], 1'b0}]}}};
			default: return {4{p[s]}};
		endcase
	endfunction

	// One APB transfer; the note is queued before the request goes out
	task automatic apb(logic [7:0] a, bit wr, logic [31:0] d, logic [32:0] exp, string name);
		q.push_back('{wr ? 4 : 0, exp, name});
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= wr;
		pwdata  <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		// No cycle limit here: a stuck slave is caught by the hang guard
		do begin
			@(posedge core_clk_in);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_in);
	endtask

	// Lets new pins and config reach the outputs (6 edges for pins), then notes expectations
	task automatic settle_and_look();
		repeat (8) @(posedge core_clk_in);
		#1;
		q.push_back('{1, {29'h0, route(fcfg, fpat, 0)}, "fast_lane"});
		q.push_back('{2, {29'h0, route(acfg, apat, 1)}, "aux_com"});
		q.push_back('{3, {24'h0, ~fcfg[6], {4{acfg[6]}}, {4{fcfg[6]}}}, "standby_oe"});
		->look;
		// Back onto a rising edge so the next stimulus starts there
		@(posedge core_clk_in);
	endtask

	// Watcher: APB answers at the completing edge, lane results on request
	always @(posedge core_clk_in) begin
		if (psel && penable && pready === 1'b1 && q.size() > 0) begin
			if (q[0].kind == 0)
				check(q[0].name, {pslverr, prdata}, q[0].exp);
			else
				check(q[0].name, {pslverr, 32'h0}, {q[0].exp[32], 32'h0});
			void'(q.pop_front());
		end
	end
	always @(look) begin
		while (q.size() > 0) begin
			case (q[0].kind)
				1: check(q[0].name, {29'h0, fout}, q[0].exp);
				2: check(q[0].name, {29'h0, aout}, q[0].exp);
				default: check(q[0].name, {24'h0, standby, aoe, foe}, q[0].exp);
			endcase
			void'(q.pop_front());
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		srst_in = 1'b1;
		ce = 1'b1;
		fpat = 16'h0;
		apat = 16'h0;
		void'($urandom(32'h86cdbfbe));
		repeat (4) @(posedge core_clk_in);
		srst_in <= 1'b0;
		// Reset state: both paths on, quad, source A
		fcfg = 8'h40;
		acfg = 8'h40;
		fpat <= 16'($urandom);
		apat <= 16'($urandom);
		apb(8'h00, 0, 0, {1'b0, 24'h0, fcfg}, "fast_reset");
		apb(8'h04, 0, 0, {1'b0, 24'h0, acfg}, "aux_reset");
		apb(8'h08, 0, 0, 33'h2, "status_reset");
		settle_and_look();
		$display("test reset done");
		// Every legal mode with random selects and random pins
		for (int m = 0; m < 3; m++) begin
			for (int r = 0; r < 4; r++) begin
				fcfg = {2'b01, 2'(m), 4'($urandom)};
				acfg = {2'b01, 2'(2 - m), 4'($urandom)};
				fpat <= 16'($urandom);
				apat <= 16'($urandom);
				apb(8'h00, 1, {24'h0, fcfg}, 33'h0, "fast_wr");
				apb(8'h04, 1, {24'h0, acfg}, 33'h0, "aux_wr");
				apb(8'h00, 0, 0, {1'b0, 24'h0, fcfg}, "fast_rd");
				settle_and_look();
			end
		end
		$display("test modes done");
		// Illegal mode code keeps the old mode, select still taken
		fcfg = {fcfg[7:4], 4'h9};
		apb(8'h00, 1, 32'h79, 33'h0, "fast_illegal");
		apb(8'h00, 0, 0, {1'b0, 24'h0, fcfg}, "fast_kept");
		apb(8'h08, 0, 0, 33'h6, "status_fast_rej");
		acfg = {acfg[7:4], 4'h5};
		apb(8'h04, 1, 32'h75, 33'h0, "aux_illegal");
		apb(8'h04, 0, 0, {1'b0, 24'h0, acfg}, "aux_kept");
		apb(8'h08, 0, 0, 33'he, "status_aux_rej");
		settle_and_look();
		$display("test illegal done");
		// Clock enable low freezes outputs while pins move; a transfer waits for it
		ce   <= 1'b0;
		fpat <= ~fpat;
		apat <= ~apat;
		repeat (8) @(posedge core_clk_in);
		#1;
		q.push_back('{1, {29'h0, route(fcfg, ~fpat, 0)}, "fast_frozen"});
		q.push_back('{2, {29'h0, route(acfg, ~apat, 1)}, "aux_frozen"});
		->look;
		@(posedge core_clk_in);
		fork
			apb(8'h00, 0, 0, {1'b0, 24'h0, fcfg}, "fast_rd_ce");
			begin
				repeat (3) @(posedge core_clk_in);
				ce <= 1'b1;
			end
		join
		settle_and_look();
		$display("test enable done");
		// Both paths disabled: standby, no aux connection
		fcfg = 8'h13;
		acfg = 8'h1c;
		apb(8'h00, 1, {24'h0, fcfg}, 33'h0, "fast_off");
		apb(8'h04, 1, {24'h0, acfg}, 33'h0, "aux_off");
		apb(8'h08, 0, 0, 33'h1, "status_off");
		fpat <= 16'hffff;
		apat <= 16'hffff;
		settle_and_look();
		$display("test disable done");
		// Unmapped places answer with an error and change nothing
		apb(8'h10, 1, 32'h7f, {1'b1, 32'h0}, "unmapped_wr");
		apb(8'h0c, 0, 0, {1'b1, 32'h0}, "unmapped_rd");
		apb(8'h00, 0, 0, {1'b0, 24'h0, fcfg}, "fast_intact");
		$display("test unmapped done");
		// Reset in mid-run restores both control words and the status
		srst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		srst_in <= 1'b0;
		fcfg = 8'h40;
		acfg = 8'h40;
		apb(8'h00, 0, 0, {1'b0, 24'h0, fcfg}, "fast_rst_mid");
		apb(8'h08, 0, 0, 33'h2, "status_rst_mid");
		settle_and_look();
		$display("test mid reset done");
		// Every note must have met its result
		check("notes_left", 33'(q.size()), 33'h0);
		stop_test();
	end
endmodule // tb_link_switch_route_select
